// ===== core/pwm_timers_and_watchdog.sv
// Notes on behaviour
// R1: One 24-bit up counter with 8-bit prescaler.
// R2: 24-bit timer compares two values against counter.
// R3: Compare writes buffered, loaded on matching compare.
// R4: Two captures, each rising, falling or both.
// R5: Capture event stores counter in its register.
// R6: 24-bit reset on rollover, compare or software.
// R7: Five interrupt sources on 24-bit timer, each enabled.
// R8: Only second compare drives 24-bit output action.
// R9: First 24-bit compare is interrupt only.
// R10: Pin level readable; general-purpose input mode too.
// R11: Four 16-bit timers, own prescaler, compares, buffer.
// R12: 16-bit reset on rollover, compare or software.
// R13: 16-bit overflow and compare interrupts, separately enabled.
// R14: 16-bit compare match applies set/clear/toggle/none.
// R15: Watchdog counts low-speed oscillator edges only.
// R16: Watchdog expiry asserts processor reset.
// R17: Writing key restart bit restarts watchdog.
// R18: Watchdog enable is set-only until device reset.
// R19: Half-timeout flag sets past half period.
// R20: Prescaler N divides by N+1, count +1.
`timescale 1ns/1ps
module pwm_timers_and_watchdog
  import pwm_timers_pkg::*;
#(
  parameter int WDT_W       = 16,
  parameter int WDT_TIMEOUT = 32768
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              capture_input_0,
  input  wire logic              capture_input_1,
  input  wire logic [NT-1:0]     timer_pin_in,
  output logic      [NT-1:0]     timer_output_pin,
  output logic      [NT-1:0]     timer_pin_oe,
  output logic      [NT-1:0]     timer_irq,
  input  wire logic              wdt_osc_clk,
  output logic                   wdt_cpu_reset
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_TIMEOUT - 1);
  localparam logic [WDT_W-1:0] WDT_HALF = WDT_W'(WDT_TIMEOUT / 2);

  typedef struct packed {
    logic [NT-1:0][CNT_W-1:0]  cnt;
    logic [NT-1:0][CNT_W-1:0]  cmp0;
    logic [NT-1:0][CNT_W-1:0]  cmp1;
    logic [NT-1:0][CNT_W-1:0]  buf0;
    logic [NT-1:0][CNT_W-1:0]  buf1;
    logic [NT-1:0][PSC_W-1:0]  pre;
    logic [NT-1:0][CTRL_W-1:0] ctrl;
    logic [NT-1:0][FLAG_W-1:0] flag;
    logic [NT-1:0]             pin;
    logic [NT-1:0]             oe;
    logic [NT-1:0]             irq;
    logic [NT-1:0]             pin_s0;
    logic [NT-1:0]             pin_s1;
    logic [1:0][CNT_W-1:0]     cap;
    logic [2:0]                cs0;
    logic [2:0]                cs1;
    logic [2:0]                osc_s;
    logic [WDT_W-1:0]          wcnt;
    logic                      wen;
    logic                      whalf;
    logic                      wrst;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
  } state_s;

  state_s        st;
  state_s        next_st;
  logic [NT-1:0] tick;
  logic [NT-1:0] m0;
  logic [NT-1:0] m1;
  logic [NT-1:0] swr;
  logic          cev0;
  logic          cev1;
  logic          wtick;
  logic          rd_setup;
  logic          wr_fire;
  logic          wd_restart;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] wmask(input int t);
    return (t == 0) ? MASK24 : MASK16;
  endfunction

  function automatic logic act_apply(input logic [1:0] a, input logic p);
    case (a)
      ACT_SET: return 1'b1;
      ACT_CLR: return 1'b0;
      ACT_TGL: return ~p;
      default: return p;
    endcase
  endfunction

  // Capture registers exist only on the wide timer.
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    logic [ROFS_W-1:0] r;
    r = a[ROFS_W-1:0];
    if (a == WDT_CTRL || a == WDT_KEY) begin
      return 1'b1;
    end
    if (a[ALIGN_W-1:0] != '0 || a[ROFS_W+:TSEL_W] >= TSEL_W'(NT)) begin
      return 1'b0;
    end
    if (r == REG_CAP0 || r == REG_CAP1) begin
      return a[ROFS_W+:TSEL_W] == '0;
    end
    return r <= REG_CAP1;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st    = st;
    tick       = '0;
    m0         = '0;
    m1         = '0;
    swr        = '0;
    cev0       = (st.ctrl[0][B_EDGE0] & st.cs0[1] & ~st.cs0[2]) | // R4
                 (st.ctrl[0][B_EDGE0+1] & ~st.cs0[1] & st.cs0[2]);
    cev1       = (st.ctrl[0][B_EDGE1] & st.cs1[1] & ~st.cs1[2]) | // R4
                 (st.ctrl[0][B_EDGE1+1] & ~st.cs1[1] & st.cs1[2]);
    wtick      = st.osc_s[1] & ~st.osc_s[2]; // R15
    rd_setup   = psel & penable & ~st.pready;
    wr_fire    = psel & penable & st.pready & pwrite & addr_ok(paddr);
    wd_restart = wr_fire & (paddr == WDT_KEY) & pwdata[W_RESTART]; // R17
    if (clk_en) begin
      next_st.cs0     = {st.cs0[1:0], capture_input_0};
      next_st.cs1     = {st.cs1[1:0], capture_input_1};
      next_st.osc_s   = {st.osc_s[1:0], wdt_osc_clk};
      next_st.pin_s0  = timer_pin_in;
      next_st.pin_s1  = st.pin_s0;
      next_st.pready  = rd_setup;
      next_st.pslverr = rd_setup & ~addr_ok(paddr);
      if (rd_setup) begin
        next_st.prdata = '0;
      end
      if (rd_setup && paddr == WDT_CTRL) begin
        next_st.prdata = {29'h0, st.wrst, st.whalf, st.wen}; // R19
      end
      for (int t = 0; t < NT; t++) begin
        // Software access comes first so that hardware events below win.
        if (paddr[ROFS_W+:TSEL_W] == TSEL_W'(t)) begin
          if (rd_setup && addr_ok(paddr)) begin
            case (paddr[ROFS_W-1:0])
              REG_CTRL: begin
                next_st.prdata = 32'(st.ctrl[t]);
              end
              REG_STAT: begin
                next_st.prdata = {23'h0, st.ctrl[t][B_GPIO] ? st.pin_s1[t] : st.pin[t], // R10
                                  3'h0, st.flag[t]};
              end
              REG_CMP0: begin
                next_st.prdata = {8'h00, st.buf0[t]};
              end
              REG_CMP1: begin
                next_st.prdata = {8'h00, st.buf1[t]};
              end
              REG_COUNT: begin
                next_st.prdata = {8'h00, st.cnt[t]};
              end
              REG_CAP0: begin
                next_st.prdata = {8'h00, st.cap[0]};
              end
              REG_CAP1: begin
                next_st.prdata = {8'h00, st.cap[1]};
              end
              default: begin
                next_st.prdata = '0;
              end
            endcase
          end
          if (wr_fire) begin
            case (paddr[ROFS_W-1:0])
              REG_CTRL: begin
                next_st.ctrl[t]          = pwdata[CTRL_W-1:0];
                next_st.ctrl[t][B_SWRST] = 1'b0;
                swr[t]                   = pwdata[B_SWRST]; // R6 R12
              end
              REG_STAT: begin
                next_st.flag[t] = st.flag[t] & ~pwdata[FLAG_W-1:0];
              end
              REG_CMP0: begin
                next_st.buf0[t] = pwdata[CNT_W-1:0] & wmask(t);
                if (!st.ctrl[t][B_BUF]) begin
                  next_st.cmp0[t] = pwdata[CNT_W-1:0] & wmask(t);
                end
              end
              REG_CMP1: begin
                next_st.buf1[t] = pwdata[CNT_W-1:0] & wmask(t);
                if (!st.ctrl[t][B_BUF]) begin
                  next_st.cmp1[t] = pwdata[CNT_W-1:0] & wmask(t);
                end
              end
              default: begin
              end
            endcase
          end
        end
        // Counting.
        tick[t] = st.ctrl[t][B_EN] & (st.pre[t] == st.ctrl[t][B_PSC+:PSC_W]); // R20 R11
        m0[t]   = tick[t] & (st.cnt[t] == st.cmp0[t]); // R2
        m1[t]   = tick[t] & (st.cnt[t] == st.cmp1[t]); // R2
        if (tick[t] || !st.ctrl[t][B_EN]) begin
          next_st.pre[t] = '0;
        end else begin
          next_st.pre[t] = st.pre[t] + 8'h01; // R20
        end
        if (swr[t]) begin
          next_st.cnt[t] = '0; // R6 R12
          next_st.pre[t] = '0;
        end else if (tick[t]) begin
          if (st.ctrl[t][B_RST+:2] == RST_CMP && m1[t]) begin
            next_st.cnt[t] = '0; // R6 R12
          end else if (st.cnt[t] == wmask(t)) begin
            // Software mode parks at full scale until the software reset bit.
            if (st.ctrl[t][B_RST+:2] != RST_SW) begin
              next_st.cnt[t]          = '0; // R6 R12
              next_st.flag[t][FL_OVF] = 1'b1; // R7 R13
            end
          end else begin
            next_st.cnt[t] = st.cnt[t] + 24'h000001; // R1 R20
          end
        end
        if (m0[t]) begin
          next_st.flag[t][FL_CMP0] = 1'b1; // R7 R13
          if (st.ctrl[t][B_BUF]) begin
            next_st.cmp0[t] = next_st.buf0[t]; // R3
          end
          if (t != 0) begin
            next_st.pin[t] = act_apply(st.ctrl[t][B_ACT0+:2], next_st.pin[t]); // R14 R9
          end
        end
        if (m1[t]) begin
          next_st.flag[t][FL_CMP1] = 1'b1; // R7 R13
          if (st.ctrl[t][B_BUF]) begin
            next_st.cmp1[t] = next_st.buf1[t]; // R3
          end
          next_st.pin[t] = act_apply(st.ctrl[t][B_ACT1+:2], next_st.pin[t]); // R8 R14
        end
        if (t == 0) begin
          if (cev0) begin
            next_st.cap[0]           = st.cnt[0]; // R5
            next_st.flag[0][FL_CAP0] = 1'b1; // R7
          end
          if (cev1) begin
            next_st.cap[1]           = st.cnt[0]; // R5
            next_st.flag[0][FL_CAP1] = 1'b1; // R7
          end
        end
        next_st.oe[t]  = ~next_st.ctrl[t][B_GPIO]; // R10
        next_st.irq[t] = |(next_st.flag[t] & next_st.ctrl[t][B_IE+:FLAG_W]); // R7 R13
      end
      // Watchdog; only presetn can drop the enable or the reset request.
      if (wr_fire && paddr == WDT_CTRL && pwdata[W_EN]) begin
        next_st.wen = 1'b1; // R18
      end
      if (!st.wen || wd_restart) begin
        next_st.wcnt = '0; // R17
      end else if (wtick && !st.wrst) begin
        if (st.wcnt == WDT_LAST) begin
          next_st.wrst = 1'b1; // R16
        end else begin
          next_st.wcnt = st.wcnt + 1'b1; // R15
        end
      end
      next_st.whalf = (st.whalf & ~wd_restart) | (st.wen & (st.wcnt >= WDT_HALF)); // R19
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata           = st.prdata;
  assign pready           = st.pready;
  assign pslverr          = st.pslverr;
  assign timer_output_pin = st.pin;
  assign timer_pin_oe     = st.oe;
  assign timer_irq        = st.irq;
  assign wdt_cpu_reset    = st.wrst;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_presc;
    clk_en && st.ctrl[0][B_EN] && !tick[0] && !swr[0] |=> st.pre[0] == $past(st.pre[0]) + 8'h01;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler step wrong"); // R20

  property p_inc;
    clk_en && tick[0] && !swr[0] && st.ctrl[0][B_RST+:2] == RST_ROLL && st.cnt[0] != MASK24
    |=> st.cnt[0] == $past(st.cnt[0]) + 24'h000001;
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not step"); // R1

  property p_ovf;
    clk_en && tick[0] && !swr[0] && st.ctrl[0][B_RST+:2] == RST_ROLL && st.cnt[0] == MASK24
    |=> st.cnt[0] == '0 && st.flag[0][FL_OVF];
  endproperty
  a_ovf: assert property (p_ovf) else $error("rollover wrong"); // R6

  property p_cmprst;
    clk_en && !swr[0] && m1[0] && st.ctrl[0][B_RST+:2] == RST_CMP |=> st.cnt[0] == '0;
  endproperty
  a_cmprst: assert property (p_cmprst) else $error("compare reset missed"); // R6

  property p_swrst;
    clk_en && swr[0] |=> st.cnt[0] == '0 && st.pre[0] == '0;
  endproperty
  a_swrst: assert property (p_swrst) else $error("software reset missed"); // R6

  property p_shadow;
    clk_en && m1[0] && st.ctrl[0][B_BUF] |=> st.cmp1[0] == st.buf1[0];
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow not loaded"); // R3

  property p_cmp0_pin;
    clk_en && m0[0] && !m1[0] |=> $stable(st.pin[0]);
  endproperty
  a_cmp0_pin: assert property (p_cmp0_pin) else $error("first compare moved pin"); // R9

  property p_cmp1_set;
    clk_en && m1[0] && st.ctrl[0][B_ACT1+:2] == ACT_SET |=> st.pin[0];
  endproperty
  a_cmp1_set: assert property (p_cmp1_set) else $error("set action missed"); // R8

  property p_tgl;
    clk_en && m0[1] && !m1[1] && st.ctrl[1][B_ACT0+:2] == ACT_TGL |=> st.pin[1] != $past(st.pin[1]);
  endproperty
  a_tgl: assert property (p_tgl) else $error("toggle action missed"); // R14

  property p_cap;
    clk_en && cev0 |=> st.cap[0] == $past(st.cnt[0]) && st.flag[0][FL_CAP0];
  endproperty
  a_cap: assert property (p_cap) else $error("capture wrong"); // R5

  property p_irq;
    clk_en && st.flag[2][FL_OVF] && st.ctrl[2][B_IE+FL_OVF] |-> st.irq[2];
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised"); // R13

  property p_wlock;
    st.wen |=> st.wen;
  endproperty
  a_wlock: assert property (p_wlock) else $error("watchdog disabled"); // R18

  property p_wfire;
    clk_en && st.wen && wtick && !wd_restart && st.wcnt == WDT_LAST |=> st.wrst [*3];
  endproperty
  a_wfire: assert property (p_wfire) else $error("watchdog did not fire"); // R16

  property p_wkick;
    clk_en && st.wen && wd_restart |=> st.wcnt == '0;
  endproperty
  a_wkick: assert property (p_wkick) else $error("restart ignored"); // R17

  property p_whalf;
    clk_en && st.wen && st.wcnt >= WDT_HALF |=> st.whalf;
  endproperty
  a_whalf: assert property (p_whalf) else $error("half flag missed"); // R19

  property p_wosc;
    clk_en && st.wen && !wtick && !wd_restart |=> $stable(st.wcnt);
  endproperty
  a_wosc: assert property (p_wosc) else $error("watchdog moved off tick"); // R15

  c_cap:   cover property (clk_en && cev1);
  c_fire:  cover property ($rose(st.wrst));
  c_match: cover property (clk_en && m1[0] && st.ctrl[0][B_BUF]);
  c_swr:   cover property (clk_en && swr[3]);

endmodule

// ===== core/pwm_timers_pkg.sv
package pwm_timers_pkg;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int NT      = 5;
  localparam int CNT_W   = 24;
  localparam int PSC_W   = 8;
  localparam int FLAG_W  = 5;
  localparam int CTRL_W  = 27;
  localparam int ADDR_W  = 8;
  localparam int ALIGN_W = 2;
  localparam int ROFS_W  = 5;
  localparam int TSEL_W  = 3;
  localparam logic [CNT_W-1:0] MASK24 = 24'hFFFFFF;
  localparam logic [CNT_W-1:0] MASK16 = 24'h00FFFF;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ROFS_W-1:0] REG_CTRL  = 5'h00;
  localparam logic [ROFS_W-1:0] REG_STAT  = 5'h04;
  localparam logic [ROFS_W-1:0] REG_CMP0  = 5'h08;
  localparam logic [ROFS_W-1:0] REG_CMP1  = 5'h0C;
  localparam logic [ROFS_W-1:0] REG_COUNT = 5'h10;
  localparam logic [ROFS_W-1:0] REG_CAP0  = 5'h14;
  localparam logic [ROFS_W-1:0] REG_CAP1  = 5'h18;
  localparam logic [ADDR_W-1:0] WDT_CTRL  = 8'hA0;
  localparam logic [ADDR_W-1:0] WDT_KEY   = 8'hA4;

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int B_PSC   = 0;
  localparam int B_EN    = 8;
  localparam int B_RST   = 9;
  localparam int B_SWRST = 11;
  localparam int B_ACT0  = 12;
  localparam int B_ACT1  = 14;
  localparam int B_BUF   = 16;
  localparam int B_GPIO  = 17;
  localparam int B_IE    = 18;
  localparam int B_EDGE0 = 23;
  localparam int B_EDGE1 = 25;
  localparam int FL_OVF  = 0;
  localparam int FL_CMP0 = 1;
  localparam int FL_CMP1 = 2;
  localparam int FL_CAP0 = 3;
  localparam int FL_CAP1 = 4;
  localparam int W_EN      = 0;
  localparam int W_RESTART = 0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_ROLL = 2'h0;
  localparam logic [1:0] RST_CMP  = 2'h1;
  localparam logic [1:0] RST_SW   = 2'h2;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_SET  = 2'h1;
  localparam logic [1:0] ACT_CLR  = 2'h2;
  localparam logic [1:0] ACT_TGL  = 2'h3;

endpackage

// ===== testbench/pwm_timers_and_watchdog_tb_top.sv
`timescale 1ns/1ps
module pwm_timers_and_watchdog_tb_top
  import pwm_timers_pkg::*;
;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  localparam logic [31:0] EN  = 32'h1 << B_EN;
  localparam logic [31:0] SWR = 32'h1 << B_SWRST;
  logic              pclk            = 1'b0;
  logic              presetn         = 1'b0;
  logic              clk_en          = 1'b1;
  logic              psel            = 1'b0;
  logic              penable         = 1'b0;
  logic              pwrite          = 1'b0;
  logic [ADDR_W-1:0] paddr           = '0;
  logic [31:0]       pwdata          = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              capture_input_0 = 1'b0;
  logic              capture_input_1 = 1'b0;
  logic [NT-1:0]     timer_pin_in    = '0;
  logic [NT-1:0]     timer_output_pin;
  logic [NT-1:0]     timer_pin_oe;
  logic [NT-1:0]     timer_irq;
  logic              wdt_osc_clk     = 1'b0;
  logic              wdt_cpu_reset;
  logic              osc_run         = 1'b0;
  logic [2:0]        osc_div         = '0;
  logic [7:0]        bad[4]          = '{8'h1C, 8'h34, 8'hA8, 8'h02};
  logic [1:0]        acts[4]         = '{ACT_SET, ACT_CLR, ACT_TGL, ACT_NONE};
  int                num_errors      = 0;
  int                tests_run       = 0;

  pwm_timers_and_watchdog #(.WDT_W(16), .WDT_TIMEOUT(16)) dut_u (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_input_0(capture_input_0), .capture_input_1(capture_input_1),
    .timer_pin_in(timer_pin_in), .timer_output_pin(timer_output_pin), .timer_pin_oe(timer_pin_oe),
    .timer_irq(timer_irq), .wdt_osc_clk(wdt_osc_clk), .wdt_cpu_reset(wdt_cpu_reset));

  always #2 pclk = ~pclk;

  // The oscillator only toggles every eight clocks, far slower than the bus clock.
  always @(posedge pclk) begin
    osc_div <= osc_div + 3'h1;
    if (osc_run && osc_div == 3'h7) begin
      wdt_osc_clk <= ~wdt_osc_clk;
    end
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [7:0] ra(input int t, input logic [4:0] o);
    return 8'(t * 32) + {3'h0, o};
  endfunction

  function automatic logic act_fn(input logic [1:0] a, input logic p);
    case (a)
      ACT_SET: return 1'b1;
      ACT_CLR: return 1'b0;
      ACT_TGL: return ~p;
      default: return p;
    endcase
  endfunction

  task automatic final_report();
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One idle edge before each setup keeps every signal to one change per time step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    logic [31:0] r, r2, cp;
    logic        e, pv;
    logic [1:0]  e1;
    int          n, p;
    void'($urandom(32'h83ca973f));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int t = 0; t < NT; t++) begin
      for (int k = 0; k < 5; k++) begin
        rd(ra(t, 5'(k * 4)), r);
        chk("reset value", 32'h0, r);
      end
    end
    foreach (bad[i]) begin
      apb(1'b0, bad[i], 32'h0, r, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, r);
    end
    for (int t = 0; t < NT; t++) begin
      n = $urandom_range(3, 0);
      wr(ra(t, REG_CTRL), 32'(n) | EN | SWR);
      rd(ra(t, REG_COUNT), r);
      repeat ((n + 1) * 8 - 4) @(posedge pclk);
      rd(ra(t, REG_COUNT), r2);
      chk("count step", 32'h8, r2 - r);
      wr(ra(t, REG_CTRL), 32'h0);
    end
    // A full 16-bit wrap is the longest stretch of the run.
    wr(ra(1, REG_CTRL), EN | SWR | (32'(RST_SW) << B_RST));
    wr(ra(2, REG_CTRL), EN | SWR | (32'h1 << (B_IE + FL_OVF)));
    wr(ra(3, REG_CTRL), EN | SWR);
    repeat (65600) @(posedge pclk);
    chk("irq ovf", 32'h1, {31'h0, timer_irq[2]});
    chk("irq masked", 32'h0, {31'h0, timer_irq[3]});
    rd(ra(2, REG_STAT), r);
    chk("ovf flag", 32'h1, r & 32'h1);
    rd(ra(1, REG_STAT), r);
    chk("sw mode ovf", 32'h0, r & 32'h1);
    rd(ra(1, REG_COUNT), r);
    chk("sw mode park", 32'hFFFF, r);
    wr(ra(2, REG_STAT), 32'h1F);
    @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, timer_irq[2]});
    for (int t = 1; t < 4; t++) begin
      wr(ra(t, REG_CTRL), 32'h0);
    end
    p = $urandom_range(40, 10);
    wr(ra(0, REG_CMP1), 32'(p));
    wr(ra(0, REG_CTRL), EN | SWR | (32'h1 << B_BUF) | (32'(RST_CMP) << B_RST) | (32'h1 << (B_IE + FL_CMP1)));
    repeat (4) begin
      repeat ($urandom_range(30, 1)) @(posedge pclk);
      rd(ra(0, REG_COUNT), r);
      chk("count period", 32'h1, {31'h0, r <= 32'(p)});
    end
    repeat (50) @(posedge pclk);
    chk("cmp1 irq", 32'h1, {31'h0, timer_irq[0]});
    wr(ra(0, REG_CMP1), 32'hC8);
    rd(ra(0, REG_CMP1), r);
    chk("buffer readback", 32'hC8, r);
    repeat (120) @(posedge pclk);
    rd(ra(0, REG_COUNT), r);
    chk("buffer loaded", 32'h1, {31'h0, r > 32'(p) && r <= 32'hC8});
    // Twenty frozen edges sit between two reads that are four counting edges apart.
    clk_en <= 1'b0;
    repeat (20) @(posedge pclk);
    clk_en <= 1'b1;
    rd(ra(0, REG_COUNT), r2);
    chk("clock enable freeze", 32'h4, r2 - r);
    wr(ra(0, REG_CTRL), 32'h0);
    for (int t = 0; t < 2; t++) begin
      pv = 1'b0;
      wr(ra(t, REG_CMP1), 32'h5);
      wr(ra(t, REG_CMP0), 32'h8);
      foreach (acts[i]) begin
        wr(ra(t, REG_CTRL), EN | SWR | (32'(RST_SW) << B_RST) | (32'(ACT_TGL) << B_ACT0) | (32'(acts[i]) << B_ACT1));
        repeat (30) @(posedge pclk);
        pv = act_fn(acts[i], pv) ^ (t != 0);
        chk("pin level", {31'h0, pv}, {31'h0, timer_output_pin[t]});
        rd(ra(t, REG_STAT), r);
        chk("pin status", {31'h0, pv}, (r >> 8) & 32'h1);
      end
      wr(ra(t, REG_CTRL), 32'h0);
    end
    for (int m = 1; m < 4; m++) begin
      e1 = ~2'(m);
      wr(ra(0, REG_CTRL), EN | SWR | (32'h1 << (B_IE + FL_CAP0)) | (32'(m) << B_EDGE0) | (32'(e1) << B_EDGE1));
      wr(ra(0, REG_STAT), 32'h1F);
      for (int s = 0; s < 2; s++) begin
        repeat ($urandom_range(6, 0)) @(posedge pclk);
        rd(ra(0, REG_COUNT), r2);
        capture_input_0 <= (s == 0);
        capture_input_1 <= (s == 0);
        repeat (8) @(posedge pclk);
        rd(ra(0, REG_STAT), r);
        chk("cap0 flag", 32'(m >> s) & 32'h1, (r >> FL_CAP0) & 32'h1);
        chk("cap1 flag", 32'(e1 >> s) & 32'h1, (r >> FL_CAP1) & 32'h1);
        chk("cap irq", 32'(m >> s) & 32'h1, {31'h0, timer_irq[0]});
        if (((m >> s) & 1) == 1) begin
          rd(ra(0, REG_CAP0), cp);
          rd(ra(0, REG_COUNT), r);
          chk("cap value", 32'h1, {31'h0, cp > r2 && cp < r});
        end
        wr(ra(0, REG_STAT), 32'h1F);
      end
    end
    n = $urandom_range(31, 0);
    timer_pin_in <= 5'(n);
    wr(ra(4, REG_CTRL), 32'h1 << B_GPIO);
    repeat (4) @(posedge pclk);
    chk("gpio oe", 32'h0, {31'h0, timer_pin_oe[4]});
    rd(ra(4, REG_STAT), r);
    chk("gpio input", 32'(n >> 4) & 32'h1, (r >> 8) & 32'h1);
    osc_run <= 1'b1;
    repeat (300) @(posedge pclk);
    chk("wdt idle", 32'h0, {31'h0, wdt_cpu_reset});
    rd(WDT_CTRL, r);
    chk("wdt off", 32'h0, r);
    wr(WDT_CTRL, 32'h1);
    wr(WDT_CTRL, 32'h0);
    rd(WDT_CTRL, r);
    chk("wdt sticky", 32'h1, r & 32'h1);
    repeat (4) begin
      wr(WDT_KEY, 32'h1);
      repeat (96) @(posedge pclk);
    end
    chk("wdt fed", 32'h0, {31'h0, wdt_cpu_reset});
    wr(WDT_KEY, 32'h1);
    osc_run <= 1'b0;
    repeat (300) @(posedge pclk);
    rd(WDT_CTRL, r);
    chk("wdt no osc", 32'h1, r);
    osc_run <= 1'b1;
    repeat (160) @(posedge pclk);
    rd(WDT_CTRL, r);
    chk("wdt half", 32'h3, r);
    chk("wdt early", 32'h0, {31'h0, wdt_cpu_reset});
    repeat (200) @(posedge pclk);
    chk("wdt expiry", 32'h1, {31'h0, wdt_cpu_reset});
    rd(WDT_CTRL, r);
    chk("wdt status", 32'h7, r);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk("reset clears wdt", 32'h0, {31'h0, wdt_cpu_reset});
    rd(WDT_CTRL, r);
    chk("wdt off again", 32'h0, r);
    final_report();
  end

  // The whole sequence needs under 75,000 cycles, so 90,000 leaves room.
  initial begin
    #360000;
    num_errors++;
    final_report();
  end
endmodule
